/* File: rtl/vfdsk_top.sv */
// serial command interpreter, display memory write port, led port and key scan
// host drives frame, serial clock and data synchronous to clock
// Notes on behaviour
// RULE1: first byte after frame falls is a command, lsb first
// RULE2: frame rising mid-byte resets receiver and drops the partial byte
// RULE3: 00 is display mode, 01 is data setting
// RULE4: mode command ignores b4 and b5
// RULE5: 10 is address setting, 11 is display control
// RULE6: sixteen by two key matrix, one bit per key stored
// RULE7: read shifts key bytes lsb first in scan order
// RULE8: after b7 of a byte, b0 of the next follows
// RULE9: four scan lines per byte, even bits return a, odd return b
// RULE10: led byte lsb first, b0..b3 to outputs, rest ignored
// RULE11: led port bit 1 turns output off, 0 turns on
// RULE12: led port bits clear to zero at reset
// RULE13: addresses 00h to 23h valid; above, data discarded
// RULE14: address pointer resets to zero
// RULE15: control sets on/off and width; reset width 1/16, off
// RULE16: one key scan cycle spans two frames into store
// RULE17: operating rate is 224 over segment slot width
// RULE18: serial output is open drain pull-down only
// RULE19: host waits 1 us before first read clock
// RULE20: host init order: data, address, data bytes, mode, control
// RULE21: address then data in own frame for chosen locations
// RULE22: data setting selecting led port then one led byte
// RULE23: host clears display memory at initialisation
// RULE24: input sampled on rising serial clock, output changes on falling
`timescale 1ns/100ps
`include "vfdsk_regs.svh"
module vfdsk_top (
    input  wire logic        clock,
    input  wire logic        reset,
    input  wire logic        transfer_frame_n,
    input  wire logic        serial_clock,
    input  wire logic        serial_data_in,
    output logic             serial_data_out_oe,
    output logic             serial_data_out,
    output logic [15:0]      segment_scan_line,
    input  wire logic        key_return_a,
    input  wire logic        key_return_b,
    output logic [3:0]       indicator_out,
    output logic             display_on,
    output logic [2:0]       pulse_width,
    output logic [3:0]       display_mode,
    output logic             key_scan_active,
    output logic [5:0]       mem_wr_addr,
    output logic [7:0]       mem_wr_data,
    output logic             mem_wr_valid,
    input  wire logic        mem_wr_ready
);
    vfdsk_pkg::vfdsk_state_t state_r;
    vfdsk_pkg::vfdsk_ctrl_t  ctrl_r;
    vfdsk_pkg::vfdsk_wr_t    wr_in_r;
    vfdsk_pkg::vfdsk_wr_t    wr_out;
    logic        sclk_d_r;
    logic [7:0]  shift_r;
    logic [2:0]  bit_cnt_r;
    logic [1:0]  op_r;
    logic        addr_incr_r;
    logic [5:0]  addr_r;
    logic [3:0]  led_r;
    logic [3:0]  mode_r;
    logic [31:0] keys_r;
    logic [31:0] key_live_r;
    logic [4:0]  rd_idx_r;
    logic        dout_r;
    logic        push_r;
    logic        fifo_ready;
    logic        fifo_valid;
    logic        sclk_rise;
    logic        sclk_fall;
    logic        byte_done;
    logic [7:0]  byte_val;
    logic        reading;
    logic [15:0] slot_cnt_r;
    logic [7:0]  slot_r;
    logic        frame_phase_r;
    logic [15:0] scan_line_r;

    function automatic logic [1:0] cmd_kind(input logic [7:0] b);
        cmd_kind = b[7:6];
    endfunction

    assign sclk_rise = serial_clock && !sclk_d_r && !transfer_frame_n;
    assign sclk_fall = !serial_clock && sclk_d_r && !transfer_frame_n;
    assign byte_val  = {serial_data_in, shift_r[7:1]};
    assign byte_done = sclk_rise && (bit_cnt_r == 3'h7);
    assign reading   = (state_r == vfdsk_pkg::VFDSK_BODY) && (op_r == `VFDSK_DS_OP_READ);

    always_ff @(posedge clock)
    begin
        // idle level of the serial clock is high; no false rise after reset
        if (reset)
            sclk_d_r <= 1'b1;
        else
            sclk_d_r <= serial_clock;
    end

    // receiver; frame going high drops any partial byte
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            state_r   <= vfdsk_pkg::VFDSK_IDLE;
            shift_r   <= 8'h00;
            bit_cnt_r <= 3'h0;
        end
        else if (transfer_frame_n)
        begin
            // RULE2: abort resets receiver
            state_r   <= vfdsk_pkg::VFDSK_IDLE;
            bit_cnt_r <= 3'h0;
        end
        else
        begin
            case (state_r)
                vfdsk_pkg::VFDSK_IDLE: state_r <= vfdsk_pkg::VFDSK_CMD;
                // RULE1: first byte is command
                vfdsk_pkg::VFDSK_CMD:  if (byte_done) state_r <= vfdsk_pkg::VFDSK_BODY;
                vfdsk_pkg::VFDSK_BODY: state_r <= vfdsk_pkg::VFDSK_BODY;
                default:               state_r <= vfdsk_pkg::VFDSK_IDLE;
            endcase
            // RULE24: sample on rising clock
            if (sclk_rise)
            begin
                shift_r   <= byte_val;
                bit_cnt_r <= bit_cnt_r + 3'h1;
            end
        end
    end

    // command decode and settings
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            op_r        <= `VFDSK_DS_OP_WRITE;
            addr_incr_r <= 1'b1;
            mode_r      <= `VFDSK_MODE_RESET;
            // RULE15: reset width 1/16, display off
            ctrl_r      <= '{display_on: 1'b0, pulse_width: `VFDSK_PW_RESET};
        end
        else if (byte_done && state_r == vfdsk_pkg::VFDSK_CMD)
        begin
            // RULE3: top bits select command
            case (cmd_kind(byte_val))
                // RULE4: b4, b5 ignored
                `VFDSK_CMD_MODE:
                    if (byte_val[3:0] != mode_r)
                    begin
                        mode_r            <= byte_val[3:0];
                        ctrl_r.display_on <= 1'b0;
                    end
                `VFDSK_CMD_DATA:
                begin
                    op_r        <= byte_val[1:0];
                    addr_incr_r <= !byte_val[2];
                end
                // RULE5: address and control
                // pointer itself is loaded in the address block
                `VFDSK_CMD_ADDR: ;
                `VFDSK_CMD_CTRL: ctrl_r <= '{display_on: byte_val[3], pulse_width: byte_val[2:0]};
                default:         ;
            endcase
        end
    end

    // address pointer and led port
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            // RULE14: pointer starts at zero
            addr_r <= `VFDSK_ADDR_RESET;
            // RULE12: all leds on
            led_r   <= `VFDSK_LED_RESET;
            push_r  <= 1'b0;
            wr_in_r <= '{addr: 6'h00, data: 8'h00};
        end
        else
        begin
            push_r <= 1'b0;
            // RULE21: address command loads the pointer
            if (byte_done && state_r == vfdsk_pkg::VFDSK_CMD
                && cmd_kind(byte_val) == `VFDSK_CMD_ADDR)
                addr_r <= byte_val[5:0];
            else if (byte_done && state_r == vfdsk_pkg::VFDSK_BODY)
            begin
                // RULE22: led port chosen by data setting
                // RULE10: low nibble only
                if (op_r == `VFDSK_DS_OP_LED)
                    led_r <= byte_val[3:0];
                // RULE13: out-of-range data dropped
                else if (op_r == `VFDSK_DS_OP_WRITE && addr_r <= `VFDSK_ADDR_LAST)
                begin
                    // address captured before the pointer moves on
                    push_r  <= 1'b1;
                    wr_in_r <= '{addr: addr_r, data: byte_val};
                    if (addr_incr_r)
                        addr_r <= addr_r + 6'h01;
                end
            end
        end
    end

    // writes stall in the fifo if memory side holds off; full drops the byte
    vfdsk_fifo #(
        .WIDTH ($bits(vfdsk_pkg::vfdsk_wr_t)),
        .DEPTH (`VFDSK_FIFO_DEPTH)
    ) u_fifo (
        .clock     (clock),
        .reset     (reset),
        .in_data   (wr_in_r),
        .in_valid  (push_r),
        .in_ready  (fifo_ready),
        .out_data  (wr_out),
        .out_valid (fifo_valid),
        .out_ready (mem_wr_ready && !mem_wr_valid)
    );

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            mem_wr_valid <= 1'b0;
            mem_wr_addr  <= 6'h00;
            mem_wr_data  <= 8'h00;
        end
        else if (fifo_valid && mem_wr_ready && !mem_wr_valid)
        begin
            mem_wr_valid <= 1'b1;
            mem_wr_addr  <= wr_out.addr;
            mem_wr_data  <= wr_out.data;
        end
        else
            mem_wr_valid <= 1'b0;
    end

    // RULE17: slot timer stands in for the scan oscillator
    always_ff @(posedge clock)
    begin
        if (reset || !ctrl_r.display_on)
        begin
            slot_cnt_r    <= 16'h0000;
            slot_r        <= 8'h00;
            frame_phase_r <= 1'b0;
            scan_line_r   <= 16'h0001;
            key_live_r    <= 32'h00000000;
        end
        else if (slot_cnt_r == `VFDSK_SLOT_CYCLES - 16'd1)
        begin
            slot_cnt_r  <= 16'h0000;
            // RULE6: one bit per key
            key_live_r[{slot_r[3:0], 1'b0}] <= key_return_a;
            key_live_r[{slot_r[3:0], 1'b1}] <= key_return_b;
            scan_line_r <= {scan_line_r[14:0], scan_line_r[15]};
            if (slot_r == `VFDSK_SLOTS_FRAME - 8'd1)
            begin
                slot_r        <= 8'h00;
                frame_phase_r <= !frame_phase_r;
            end
            else
                slot_r <= slot_r + 8'h01;
        end
        else
            slot_cnt_r <= slot_cnt_r + 16'h0001;
    end

    // RULE16: store updated every second frame
    always_ff @(posedge clock)
    begin
        if (reset)
            keys_r <= 32'h00000000;
        else if (ctrl_r.display_on && frame_phase_r
                 && slot_cnt_r == `VFDSK_SLOT_CYCLES - 16'd1
                 && slot_r == `VFDSK_SLOTS_FRAME - 8'd1 && !reading)
            keys_r <= key_live_r;
    end

    // read shifter
    always_ff @(posedge clock)
    begin
        if (reset || transfer_frame_n)
        begin
            rd_idx_r <= 5'h00;
            dout_r   <= 1'b1;
        end
        // RULE24: change after falling clock
        else if (reading && sclk_fall)
        begin
            // RULE7: lsb first in scan order
            // RULE8: wraps into next byte
            // RULE9: bit 2n return a, 2n+1 return b
            dout_r   <= keys_r[rd_idx_r];
            rd_idx_r <= rd_idx_r + 5'h01;
        end
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            serial_data_out_oe <= 1'b0;
            serial_data_out    <= 1'b0;
            indicator_out      <= 4'hf;
            segment_scan_line  <= 16'h0000;
            display_on         <= 1'b0;
            pulse_width        <= `VFDSK_PW_RESET;
            display_mode       <= `VFDSK_MODE_RESET;
            key_scan_active    <= 1'b0;
        end
        else
        begin
            // RULE18: only pulls low
            serial_data_out_oe <= reading && !dout_r;
            serial_data_out    <= 1'b0;
            // RULE11: bit 1 means off; output high is on
            indicator_out      <= ~led_r;
            segment_scan_line  <= ctrl_r.display_on ? scan_line_r : 16'h0000;
            display_on         <= ctrl_r.display_on;
            pulse_width        <= ctrl_r.pulse_width;
            display_mode       <= mode_r;
            key_scan_active    <= ctrl_r.display_on;
        end
    end
endmodule

/* File: rtl/vfdsk_regs.svh */
// constants of the serial command and key-scan block
// assumes a 100 MHz system clock; serial pins sampled synchronously
`ifndef VFDSK_REGS_SVH
`define VFDSK_REGS_SVH
`define VFDSK_CMD_MODE      2'h0
`define VFDSK_CMD_DATA      2'h1
`define VFDSK_CMD_ADDR      2'h2
`define VFDSK_CMD_CTRL      2'h3
`define VFDSK_DS_OP_WRITE   2'h0
`define VFDSK_DS_OP_LED     2'h1
`define VFDSK_DS_OP_READ    2'h2
`define VFDSK_ADDR_LAST     6'h23
`define VFDSK_RAM_DEPTH     36
`define VFDSK_KEY_BYTES     4
`define VFDSK_LED_RESET     4'h0
`define VFDSK_ADDR_RESET    6'h00
`define VFDSK_PW_RESET      3'h0
`define VFDSK_MODE_RESET    4'h7
`define VFDSK_SLOT_CYCLES   16'd1000
`define VFDSK_SLOTS_FRAME   8'd16
`define VFDSK_FIFO_DEPTH    8
`endif

/* File: rtl/vfdsk_pkg.sv */
// types of the serial command and key-scan block
// used by vfdsk_top only
package vfdsk_pkg;
    typedef struct packed {
        logic       display_on;
        logic [2:0] pulse_width;
    } vfdsk_ctrl_t;
    typedef struct packed {
        logic [5:0] addr;
        logic [7:0] data;
    } vfdsk_wr_t;
    typedef enum logic [2:0] {
        VFDSK_IDLE = 3'b001,
        VFDSK_CMD  = 3'b010,
        VFDSK_BODY = 3'b100
    } vfdsk_state_t;
endpackage

/* File: rtl/vfdsk_fifo.sv */
// parameterised valid/ready fifo
// single clock, synchronous active-high reset
`timescale 1ns/100ps
module vfdsk_fifo #(
    parameter int WIDTH = 14,
    parameter int DEPTH = 8
) (
    input  wire logic             clock,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW:0]      wp_r;
    logic [AW:0]      rp_r;
    logic             push;
    logic             pop;
    assign in_ready  = (wp_r - rp_r) != (AW+1)'(DEPTH);
    assign out_valid = wp_r != rp_r;
    assign out_data  = mem_r[rp_r[AW-1:0]];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    always_ff @(posedge clock)
    begin
        if (push)
            mem_r[wp_r[AW-1:0]] <= in_data;
    end
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            wp_r <= '0;
            rp_r <= '0;
        end
        else
        begin
            if (push)
                wp_r <= wp_r + 1'b1;
            if (pop)
                rp_r <= rp_r + 1'b1;
        end
    end
endmodule

/* File: verification/vfdsk_top_asserts.sv */
// port checker for vfdsk_top
// bound to every vfdsk_top instance; one clock, sync reset
`timescale 1ns/100ps
module vfdsk_top_asserts (
    input wire logic        clock,
    input wire logic        reset,
    input wire logic        transfer_frame_n,
    input wire logic        serial_clock,
    input wire logic        serial_data_out_oe,
    input wire logic        serial_data_out,
    input wire logic [15:0] segment_scan_line,
    input wire logic [3:0]  indicator_out,
    input wire logic        display_on,
    input wire logic [2:0]  pulse_width,
    input wire logic [3:0]  display_mode,
    input wire logic        key_scan_active,
    input wire logic [5:0]  mem_wr_addr,
    input wire logic        mem_wr_valid,
    input wire logic        mem_wr_ready
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    // scan outputs are registered in the same cycle as display_on
    sequence scan_off;
        !display_on ##1 !display_on;
    endsequence
    led_reset_a: assert property (
        $fell(reset) |-> indicator_out == 4'hf) else $error("led reset value");
    ctrl_reset_a: assert property (
        $fell(reset) |-> !display_on && pulse_width == 3'h0) else $error("ctrl reset");
    scan_halt_a: assert property (
        key_scan_active |-> display_on) else $error("scan while display off");
    scan_idle_a: assert property (
        scan_off |-> segment_scan_line == 16'h0) else $error("scan line while off");
    scan_onehot_a: assert property (
        $onehot0(segment_scan_line)) else $error("scan lines not one-hot");
    drain_only_a: assert property (
        serial_data_out == 1'b0) else $error("data out driven high");
    out_edge_a: assert property (
        $changed(serial_data_out_oe) |-> !$past(serial_clock) || $past(transfer_frame_n))
        else $error("data out moved with serial clock high");
    led_frame_a: assert property (
        $changed(indicator_out) |-> !$past(transfer_frame_n, 2)) else $error("led outside frame");
    ctrl_frame_a: assert property (
        $changed({display_on, pulse_width, display_mode}) |-> !$past(transfer_frame_n, 2))
        else $error("setting changed outside frame");
    addr_range_a: assert property (
        mem_wr_valid |-> mem_wr_addr <= 6'h23) else $error("write above last address");
    wr_pulse_a: assert property (
        mem_wr_valid |=> !mem_wr_valid) else $error("write pulse too long");
    wr_wait_a: assert property (
        mem_wr_valid |-> $past(mem_wr_ready)) else $error("write without ready");
endmodule
bind vfdsk_top vfdsk_top_asserts vfdsk_top_asserts_i (
    .clock(clock), .reset(reset), .transfer_frame_n(transfer_frame_n),
    .serial_clock(serial_clock), .serial_data_out_oe(serial_data_out_oe),
    .serial_data_out(serial_data_out), .segment_scan_line(segment_scan_line),
    .indicator_out(indicator_out), .display_on(display_on), .pulse_width(pulse_width),
    .display_mode(display_mode), .key_scan_active(key_scan_active),
    .mem_wr_addr(mem_wr_addr), .mem_wr_valid(mem_wr_valid), .mem_wr_ready(mem_wr_ready)
);

/* File: verification/vfdsk_host_model.sv */
// host model: frames command and data bytes on the serial link
// line is the resolved open-drain data wire; 4-cycle clock phases
`timescale 1ns/100ps
module vfdsk_host_model (
    input  wire logic clock,
    input  wire logic line,
    output logic      transfer_frame_n,
    output logic      serial_clock,
    output logic      serial_data_in
);
    initial
    begin
        transfer_frame_n = 1'b1;
        serial_clock     = 1'b1;
        serial_data_in   = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic put(input logic [7:0] b, input int n);
        for (int i = 0; i < n; i++)
        begin
            serial_clock = 1'b0;
            serial_data_in = b[i];
            tick(4);
            serial_clock = 1'b1;
            tick(4);
        end
    endtask
    task automatic get(output logic [31:0] v);
        for (int i = 0; i < 32; i++)
        begin
            serial_clock = 1'b0;
            serial_data_in = ~serial_data_in;
            tick(4);
            v[i] = line;
            serial_clock = 1'b1;
            tick(4);
        end
    endtask
    task automatic frame(input logic [7:0] q[$], input int nb, input bit rd,
                         output logic [31:0] v);
        v = 32'h0;
        transfer_frame_n = 1'b0;
        tick(4);
        foreach (q[i])
            put(q[i], (i == q.size() - 1) ? nb : 8);
        if (rd)
        begin
            tick(100);
            get(v);
        end
        tick(4);
        transfer_frame_n = 1'b1;
        tick(8);
    endtask
endmodule

/* File: verification/vfdsk_top_tb.sv */
// self-checking bench for vfdsk_top driven by vfdsk_host_model
// keys closed: scan line 3 on return a, scan line 14 on return b
`timescale 1ns/100ps
module vfdsk_top_tb;
    logic        clock = 1'b0;
    logic        reset = 1'b1;
    logic        wr_ready = 1'b1;
    logic        frame_n, sclk, sdi, oe, sdo, key_a, key_b, on, scan, wr_valid;
    logic [15:0] seg;
    logic [3:0]  led, mode;
    logic [2:0]  pw;
    logic [5:0]  wr_addr;
    logic [7:0]  wr_data;
    wire         line;
    int          errors = 0;
    int          total_checks = 0;
    logic [5:0]  wa[$];
    logic [7:0]  wd[$];
    always #5 clock = ~clock;
    assign line = (oe === 1'b1) ? sdo : 1'b1;
    assign key_a = (seg[2] === 1'b1);
    assign key_b = (seg[13] === 1'b1);
    vfdsk_top vfdsk_top_i (
        .clock(clock), .reset(reset), .transfer_frame_n(frame_n), .serial_clock(sclk),
        .serial_data_in(sdi), .serial_data_out_oe(oe), .serial_data_out(sdo),
        .segment_scan_line(seg), .key_return_a(key_a), .key_return_b(key_b),
        .indicator_out(led), .display_on(on), .pulse_width(pw), .display_mode(mode),
        .key_scan_active(scan), .mem_wr_addr(wr_addr), .mem_wr_data(wr_data),
        .mem_wr_valid(wr_valid), .mem_wr_ready(wr_ready));
    vfdsk_host_model vfdsk_host_model_i (
        .clock(clock), .line(line), .transfer_frame_n(frame_n), .serial_clock(sclk),
        .serial_data_in(sdi));
    always @(posedge clock)
        if (wr_valid === 1'b1)
        begin
            wa.push_back(wr_addr);
            wd.push_back(wr_data);
        end
    task automatic check(input string what, input logic [31:0] seen, exp);
        total_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic send(input logic [7:0] q[$], input int nb = 8);
        logic [31:0] v;
        vfdsk_host_model_i.frame(q, nb, 1'b0, v);
    endtask
    task automatic test_reset;
        check("led", led, 4'hf);
        check("ctrl", {on, pw, scan}, 5'h0);
        $display("end reset test");
    endtask
    // ten bytes into eight slots while the memory stalls
    task automatic test_fifo;
        logic [7:0] q[$];
        wr_ready = 1'b0;
        q = '{8'h40};
        for (int i = 0; i < 10; i++)
            q.push_back(8'h10 + 8'(i));
        send(q);
        check("held", wa.size(), 0);
        wr_ready = 1'b1;
        vfdsk_host_model_i.tick(40);
        check("count", wa.size(), 8);
        foreach (wa[i])
            check("write", {wa[i], wd[i]}, {6'(i), 8'h10 + 8'(i)});
        wa.delete();
        wd.delete();
        $display("end fifo test");
    endtask
    task automatic test_mem;
        send('{8'h44});
        send('{8'h85, 8'h3c});
        send('{8'ha3, 8'h7e});
        send('{8'ha4, 8'h11});
        send('{8'h40, 8'h22});
        check("writes", wa.size(), 2);
        check("first", {wa[0], wd[0]}, {6'h05, 8'h3c});
        check("last", {wa[1], wd[1]}, {6'h23, 8'h7e});
        $display("end memory test");
    endtask
    task automatic test_led;
        logic [7:0] pat[3] = '{8'hf5, 8'h0f, 8'hf0};
        logic [3:0] exp[3] = '{4'ha, 4'h0, 4'hf};
        foreach (pat[i])
        begin
            send('{8'h41, pat[i]});
            check("led", led, exp[i]);
        end
        send('{8'h41, 8'hff}, 4);
        check("aborted", led, 4'hf);
        send('{8'h41, 8'hfc});
        check("after abort", led, 4'h3);
        $display("end led test");
    endtask
    task automatic test_ctrl;
        send('{8'h35});
        check("mode", mode, 4'h5);
        send('{8'h02});
        check("mode", mode, 4'h2);
        send('{8'hcd});
        check("ctrl", {on, pw}, 4'hd);
        send('{8'hc3});
        check("ctrl", {on, pw}, 4'h3);
        $display("end control test");
    endtask
    // power-up order, clearing all 36 locations on the way
    task automatic test_init;
        logic [7:0] q[$];
        wa.delete();
        wd.delete();
        q = '{8'h80};
        for (int i = 0; i < 36; i++)
            q.push_back(8'h00);
        send('{8'h40});
        send(q);
        send('{8'h07});
        send('{8'hcf});
        check("cleared", wa.size(), 36);
        foreach (wa[i])
            check("clear", {wa[i], wd[i]}, {6'(i), 8'h00});
        check("mode", mode, 4'h7);
        check("ctrl", {on, pw}, 4'hf);
        wa.delete();
        wd.delete();
        $display("end init test");
    endtask
    // two frames of 16000 cycles fill the key store
    task automatic test_keys;
        logic [31:0] v;
        send('{8'hc8});
        check("scan", scan, 1'b1);
        vfdsk_host_model_i.tick(40000);
        vfdsk_host_model_i.frame('{8'h42}, 8, 1'b1, v);
        check("keys", v, 32'h0800_0010);
        $display("end key test");
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        repeat (3) @(posedge clock);
        #1;
        reset = 1'b0;
        test_reset;
        test_fifo;
        test_mem;
        test_led;
        test_ctrl;
        test_init;
        test_keys;
        print_verdict;
    end
    // tests need about 45000 cycles
    initial
    begin
        #800000;
        errors++;
        print_verdict;
    end
endmodule
